// file: logic/pivec_top.sv
// Top of the prioritized interrupt vectoring block.
// Assumes request pulses, pins and control inputs are synchronous to i_sys_clk.
`timescale 1ns/1ps
`default_nettype none

module pivec_top #(
    parameter bit HAS_ADC = 1'b1,
    parameter logic [7:0] PA_PRESENT = 8'hff,
    parameter logic [3:0] PC_PRESENT = 4'hf
) (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    // Hardware request sources.
    input wire logic [7:0] i_periph_pulse,
    input wire logic [2:0] i_trap_pulse,
    input wire logic [7:0] i_pa_pin,
    input wire logic [7:0] i_pa_edge_fall,
    input wire logic [3:0] i_pc_pin,
    // Software control.
    input wire logic i_master_irq_enable,
    input wire logic [19:0] i_src_enable,
    input wire logic [39:0] i_src_level,
    input wire logic [19:0] i_sw_set,
    input wire logic [19:0] i_sw_clear,
    // Processor side.
    output logic o_irq_req,
    output logic [15:0] o_vec_msb_addr,
    output logic [15:0] o_vec_lsb_addr,
    output logic o_irq_is_trap,
    input wire logic i_irq_ack,
    output logic [19:0] o_pending
);

    localparam int N = pivec_pkg::NUM_ENT;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin edge detection.

    logic [7:0] pa_prev_q, pa_prev_d;
    logic [3:0] pc_prev_q, pc_prev_d;
    logic armed_q, armed_d;
    logic [7:0] pa_edge;
    logic [3:0] pc_edge;

    // Edges are ignored in the first cycle after reset so a pin already high is not an edge.
    always_comb begin
        pa_prev_d = i_pa_pin;
        pc_prev_d = i_pc_pin;
        armed_d = 1'b1;
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pa_prev_q <= 8'h00;
            pc_prev_q <= 4'h0;
            armed_q <= 1'b0;
        end else begin
            pa_prev_q <= pa_prev_d;
            pc_prev_q <= pc_prev_d;
            armed_q <= armed_d;
        end
    end

    for (genvar g = 0; g < 8; g++) begin : g_pa_edge
        assign pa_edge[g] = armed_q && PA_PRESENT[g] &&
            (i_pa_edge_fall[g] ? (pa_prev_q[g] && !i_pa_pin[g])
                               : (!pa_prev_q[g] && i_pa_pin[g]));
    end

    for (genvar g = 0; g < 4; g++) begin : g_pc_edge
        assign pc_edge[g] = armed_q && PC_PRESENT[g] && (pc_prev_q[g] != i_pc_pin[g]);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Source mapping and pending bits.

    logic [N-1:0] pend_q, pend_d;
    logic [N-1:0] src_set, src_clr, present;
    logic [N-1:0][pivec_pkg::LVL_W-1:0] lvl;
    logic [N-1:0] en_mask;
    logic req_q, req_d;
    logic trap_q, trap_d;
    logic [pivec_pkg::IDX_W-1:0] idx_q, idx_d;
    logic [pivec_pkg::VEC_W-1:0] vec_q, vec_d;

    pivec_sel_if sel ();

    pivec_pick u_pick (
        .sel(sel)
    );

    always_comb begin
        src_set = '0;
        src_clr = '0;
        present = '1;
        en_mask = '0;
        lvl = '0;
        // Twelve pin and eight peripheral sources, two shared vectors in each group.
        src_set[pivec_pkg::E_WDT] = i_periph_pulse[pivec_pkg::P_WDT];
        for (int p = 0; p < 5; p++) begin
            src_set[5'(pivec_pkg::E_T1 + p)] = i_periph_pulse[pivec_pkg::P_T1 + p];
        end
        src_set[pivec_pkg::E_SDROP] = i_periph_pulse[pivec_pkg::P_SDROP];
        src_set[pivec_pkg::E_CMP] = i_periph_pulse[pivec_pkg::P_CMP];
        src_set[pivec_pkg::E_POSC] = i_trap_pulse[pivec_pkg::TR_POSC];
        src_set[pivec_pkg::E_WOSC] = i_trap_pulse[pivec_pkg::TR_WOSC];
        src_set[pivec_pkg::E_ILL] = i_trap_pulse[pivec_pkg::TR_ILL];
        src_set[pivec_pkg::E_PA7] = pa_edge[7];
        src_set[pivec_pkg::E_PA6] = pa_edge[6];
        for (int p = 0; p < 6; p++) begin
            src_set[5'(pivec_pkg::E_PA5 + p)] = pa_edge[5 - p];
            present[5'(pivec_pkg::E_PA5 + p)] = PA_PRESENT[5 - p];
        end
        for (int p = 0; p < 4; p++) begin
            src_set[5'(pivec_pkg::E_PC3 + p)] = pc_edge[3 - p];
            present[5'(pivec_pkg::E_PC3 + p)] = PC_PRESENT[3 - p];
        end
        present[pivec_pkg::E_PA7] = PA_PRESENT[7];
        present[pivec_pkg::E_PA6] = PA_PRESENT[6];
        present[pivec_pkg::E_ADC] = HAS_ADC;
        // Software view: interrupt source k lives at entry irq_entry(k).
        for (int k = 0; k < pivec_pkg::NUM_IRQ; k++) begin
            src_set[pivec_pkg::irq_entry(k)] = src_set[pivec_pkg::irq_entry(k)] | i_sw_set[k];
            src_clr[pivec_pkg::irq_entry(k)] = i_sw_clear[k];
            en_mask[pivec_pkg::irq_entry(k)] = i_src_enable[k] & i_master_irq_enable;
            lvl[pivec_pkg::irq_entry(k)] = i_src_level[2*k +: 2];
        end
        // Reset and traps are always top level and never masked.
        lvl[pivec_pkg::E_WDT] = pivec_pkg::LVL_TOP;
        for (int t = 0; t < 5; t++) begin
            if (t != 1) begin
                lvl[t] = pivec_pkg::LVL_TOP;
                en_mask[t] = 1'b1;
            end
        end
        // The acknowledged entry clears; a new pulse in that cycle still wins.
        if (req_q && i_irq_ack) begin
            src_clr[idx_q] = 1'b1;
        end
        pend_d = ((pend_q & ~src_clr) | src_set) & present;
    end

    assign sel.elig = pend_d & en_mask;
    assign sel.lvl = lvl;

    // Selection is made on next-state pending bits so an acked entry never shows twice.
    always_comb begin
        req_d = sel.win_valid;
        idx_d = sel.win_idx;
        vec_d = pivec_pkg::vec_of(sel.win_idx);
        trap_d = sel.win_valid && (sel.win_idx == pivec_pkg::E_RESET ||
            (sel.win_idx >= pivec_pkg::E_POSC && sel.win_idx <= pivec_pkg::E_ILL));
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pend_q <= pivec_pkg::PEND_RST;
            req_q <= 1'b0;
            idx_q <= pivec_pkg::E_RESET;
            vec_q <= pivec_pkg::VEC_RESET;
            trap_q <= 1'b0;
        end else begin
            pend_q <= pend_d;
            req_q <= req_d;
            idx_q <= idx_d;
            vec_q <= vec_d;
            trap_q <= trap_d;
        end
    end

    assign o_irq_req = req_q;
    assign o_vec_msb_addr = vec_q;
    assign o_vec_lsb_addr = vec_q | pivec_pkg::VEC_LSB;
    assign o_irq_is_trap = trap_q;

    always_comb begin
        for (int k = 0; k < pivec_pkg::NUM_IRQ; k++) begin
            o_pending[k] = pend_q[pivec_pkg::irq_entry(k)];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    logic beaten_d, beaten_q;

    // Independent check of the selector: did any eligible entry outrank the winner?
    always_comb begin
        beaten_d = 1'b0;
        for (int j = 0; j < N; j++) begin
            if (sel.elig[j] && (sel.lvl[j] > sel.lvl[sel.win_idx] ||
                (sel.lvl[j] == sel.lvl[sel.win_idx] && 5'(j) < sel.win_idx))) begin
                beaten_d = 1'b1;
            end
        end
        if (sel.win_valid != (|sel.elig)) begin
            beaten_d = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            beaten_q <= 1'b0;
        end else begin
            beaten_q <= beaten_d;
        end
    end

    chk_rank_level_order: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n) !beaten_q)
        else $error("Selected request is outranked by another eligible request.");

    chk_vec_byte_pair: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        o_irq_req |-> (o_vec_msb_addr[0] == 1'b0) && (o_vec_lsb_addr == o_vec_msb_addr + 16'h0001))
        else $error("Vector byte addresses are not an even and odd pair.");

    // The first edge after release still shows the request flops at their reset values.
    chk_reset_vec_first: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        armed_q && pend_q[pivec_pkg::E_RESET]
        |-> o_irq_req && o_irq_is_trap && (o_vec_msb_addr == 16'h0002))
        else $error("Pending reset is not presented at vector 0002H.");

    chk_trap_order_osc: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        o_irq_req && (o_vec_msb_addr == 16'h003c) |-> !pend_q[pivec_pkg::E_POSC] && !pend_q[0])
        else $error("Watchdog oscillator trap served ahead of higher trap.");

    chk_illegal_trap_rank: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        o_irq_req && (o_vec_msb_addr == 16'h0006) |-> o_irq_is_trap && (pend_q[3:2] == 2'b00))
        else $error("Illegal instruction trap served ahead of oscillator traps.");

    chk_master_gate_off: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        !i_master_irq_enable && (i_trap_pulse == 3'h0) && !pend_q[0] && (pend_q[4:2] == 3'h0)
        |=> !o_irq_req)
        else $error("Request forwarded while master enable is clear.");

    chk_ack_clears_pend: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        o_irq_req && i_irq_ack && !src_set[idx_q] |=> !pend_q[$past(idx_q)])
        else $error("Acknowledged request stays pending.");

    chk_pulse_latches: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        i_periph_pulse[2] |=> pend_q[6] [*2] or (pend_q[6] ##1 $past(src_clr[6])))
        else $error("Timer 0 pulse was not latched into its pending bit.");

    chk_pc_both_edges: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        armed_q && PC_PRESENT[0] && (i_pc_pin[0] != pc_prev_q[0]) |=> pend_q[pivec_pkg::E_PC0])
        else $error("Port C pin 0 edge did not set its pending bit.");

    chk_pa_rise_edge: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        armed_q && PA_PRESENT[0] && !i_pa_edge_fall[0] && !pa_prev_q[0] && i_pa_pin[0]
        |=> pend_q[pivec_pkg::E_PA0])
        else $error("Port A pin 0 rising edge did not set its pending bit.");

    chk_shared_vec_pa7: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        o_irq_req && (idx_q == pivec_pkg::E_SDROP) |-> o_vec_msb_addr == 16'h0018)
        else $error("Supply drop request does not share vector 0018H.");

    chk_wdt_rank_vec: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        o_irq_req && (idx_q == pivec_pkg::E_WDT)
        |-> (o_vec_msb_addr == 16'h0004) && !o_irq_is_trap && !pend_q[pivec_pkg::E_RESET])
        else $error("Watchdog request has the wrong vector or rank.");

    chk_adc_vec_addr: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        o_irq_req && (idx_q == pivec_pkg::E_ADC) |-> o_vec_msb_addr == 16'h0016)
        else $error("Converter request is not at vector 0016H.");

    chk_pa0_vec_addr: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        o_irq_req && (idx_q == pivec_pkg::E_PA0) |-> o_vec_msb_addr == 16'h0026)
        else $error("Port A pin 0 request is not at vector 0026H.");

    chk_pc0_vec_addr: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        o_irq_req && (idx_q == pivec_pkg::E_PC0) |-> o_vec_msb_addr == 16'h0036)
        else $error("Port C pin 0 request is not at vector 0036H.");

    chk_trap_vec_set: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        o_irq_is_trap |-> o_irq_req &&
            (o_vec_msb_addr inside {16'h0002, 16'h003a, 16'h003c, 16'h0006}))
        else $error("Trap flag raised for a vector that is not reset or a trap.");

    // The watchdog may share the top level with a trap and then outranks it.
    chk_trap_beats_gate: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        i_trap_pulse[pivec_pkg::TR_ILL]
        |=> o_irq_req && (o_irq_is_trap || (idx_q == pivec_pkg::E_WDT)))
        else $error("Illegal instruction trap was not presented the next cycle.");

    chk_ack_moves_on: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        o_irq_req && i_irq_ack && !src_set[idx_q] |=> !o_irq_req || (idx_q != $past(idx_q)))
        else $error("Acknowledged request is presented again.");

endmodule

`default_nettype wire

// file: logic/pivec_pkg.sv
// Constants for the prioritized interrupt vectoring block: entry indices, vectors, levels.
// Assumes one system clock and that every request input is synchronous to it.
//
// Overview of operation
// - Vector MSB at even address, LSB next.
// - Twenty request sources onto eighteen vectors.
// - Twelve pin sources, eight peripheral sources.
// - Eight single-edge pins, four dual-edge pins.
// - Each source gets one of four levels.
// - Vectored service; polling is left undisturbed.
// - Fixed ranking breaks ties within one level.
// - Reset ranks first, vector 0002H, no interrupt.
// - Watchdog request next, vector 0004H.
// - Oscillator fail traps 003AH then 003CH.
// - Illegal instruction trap 0006H below those.
// - Peripheral order and vectors; some reserved.
// - Pin A7 shares 0018H with supply drop.
// - Pin A6 shares 001AH with comparator.
// - Pins A5 to A0 use 001CH to 0026H.
// - Pins C3 to C0, both edges, 0030H-0036H.
// - Absent pins or converter give no sources.
// - Watchdog and supply drop can interrupt.
// - Higher level always beats lower level.
// - Master enable gates vectored delivery only.
// - Single-cycle pulses latch into pending bits.
// - Acknowledge or software zero-write clears pending.

package pivec_pkg;

    localparam int NUM_ENT = 24;
    localparam int NUM_IRQ = 20;
    localparam int IDX_W = 5;
    localparam int VEC_W = 16;
    localparam int LVL_W = 2;

    // Entry indices in fixed rank order, index 0 ranks highest.
    localparam logic [IDX_W-1:0] E_RESET = 5'h00;
    localparam logic [IDX_W-1:0] E_WDT = 5'h01;
    localparam logic [IDX_W-1:0] E_POSC = 5'h02;
    localparam logic [IDX_W-1:0] E_WOSC = 5'h03;
    localparam logic [IDX_W-1:0] E_ILL = 5'h04;
    localparam logic [IDX_W-1:0] E_T1 = 5'h05;
    localparam logic [IDX_W-1:0] E_ADC = 5'h09;
    localparam logic [IDX_W-1:0] E_PA7 = 5'h0a;
    localparam logic [IDX_W-1:0] E_SDROP = 5'h0b;
    localparam logic [IDX_W-1:0] E_PA6 = 5'h0c;
    localparam logic [IDX_W-1:0] E_CMP = 5'h0d;
    localparam logic [IDX_W-1:0] E_PA5 = 5'h0e;
    localparam logic [IDX_W-1:0] E_PA0 = 5'h13;
    localparam logic [IDX_W-1:0] E_PC3 = 5'h14;
    localparam logic [IDX_W-1:0] E_PC0 = 5'h17;

    // Peripheral pulse input bit positions.
    localparam int P_WDT = 0;
    localparam int P_T1 = 1;
    localparam int P_ADC = 5;
    localparam int P_SDROP = 6;
    localparam int P_CMP = 7;

    // Trap pulse input bit positions.
    localparam int TR_POSC = 0;
    localparam int TR_WOSC = 1;
    localparam int TR_ILL = 2;

    localparam logic [NUM_ENT-1:0] PEND_RST = 24'h00_0001;
    localparam logic [LVL_W-1:0] LVL_TOP = 2'h3;

    localparam logic [VEC_W-1:0] VEC_RESET = 16'h0002;
    localparam logic [VEC_W-1:0] VEC_WDT = 16'h0004;
    localparam logic [VEC_W-1:0] VEC_ILL = 16'h0006;
    localparam logic [VEC_W-1:0] VEC_T1 = 16'h000a;
    localparam logic [VEC_W-1:0] VEC_T0 = 16'h000c;
    localparam logic [VEC_W-1:0] VEC_URX = 16'h000e;
    localparam logic [VEC_W-1:0] VEC_UTX = 16'h0010;
    localparam logic [VEC_W-1:0] VEC_ADC = 16'h0016;
    localparam logic [VEC_W-1:0] VEC_PA7 = 16'h0018;
    localparam logic [VEC_W-1:0] VEC_PA6 = 16'h001a;
    localparam logic [VEC_W-1:0] VEC_PA5 = 16'h001c;
    localparam logic [VEC_W-1:0] VEC_PC3 = 16'h0030;
    localparam logic [VEC_W-1:0] VEC_POSC = 16'h003a;
    localparam logic [VEC_W-1:0] VEC_WOSC = 16'h003c;
    localparam logic [VEC_W-1:0] VEC_STEP = 16'h0002;
    localparam logic [VEC_W-1:0] VEC_LSB = 16'h0001;

    // Vector of each entry; shared vectors give two entries one address.
    function automatic logic [VEC_W-1:0] vec_of(input logic [IDX_W-1:0] idx);
        logic [VEC_W-1:0] v;
        v = VEC_RESET;
        unique case (idx)
            5'h00: v = VEC_RESET;
            5'h01: v = VEC_WDT;
            5'h02: v = VEC_POSC;
            5'h03: v = VEC_WOSC;
            5'h04: v = VEC_ILL;
            5'h05: v = VEC_T1;
            5'h06: v = VEC_T0;
            5'h07: v = VEC_URX;
            5'h08: v = VEC_UTX;
            5'h09: v = VEC_ADC;
            5'h0a, 5'h0b: v = VEC_PA7;
            5'h0c, 5'h0d: v = VEC_PA6;
            5'h0e, 5'h0f, 5'h10, 5'h11, 5'h12, 5'h13: v = VEC_PA5 + VEC_STEP * 16'(idx - E_PA5);
            5'h14, 5'h15, 5'h16, 5'h17: v = VEC_PC3 + VEC_STEP * 16'(idx - E_PC3);
            default: v = VEC_RESET;
        endcase
        return v;
    endfunction

    // Entry that holds interrupt source k (software index 0..19).
    function automatic logic [IDX_W-1:0] irq_entry(input int k);
        return (k == 0) ? E_WDT : 5'(k + 4);
    endfunction

endpackage

// file: logic/pivec_sel_if.sv
// Interface between the pending-bit logic and the rank selector.
// Assumes both ends sit in the same clock domain; the signals are combinational.
`timescale 1ns/1ps
`default_nettype none

interface pivec_sel_if;
    logic [pivec_pkg::NUM_ENT-1:0] elig;
    logic [pivec_pkg::NUM_ENT-1:0][pivec_pkg::LVL_W-1:0] lvl;
    logic win_valid;
    logic [pivec_pkg::IDX_W-1:0] win_idx;

    modport ctrl (output elig, output lvl, input win_valid, input win_idx);
    modport pick (input elig, input lvl, output win_valid, output win_idx);
endinterface

`default_nettype wire

// file: logic/pivec_pick.sv
// Rank selector: picks the highest level, then the lowest entry index.
// Assumes elig and lvl are settled combinationally in the same cycle.
`timescale 1ns/1ps
`default_nettype none

module pivec_pick (
    // Selection carrier.
    pivec_sel_if.pick sel
);

    // Scanning from the lowest rank upward with >= lets a better rank take over ties.
    always_comb begin
        logic [pivec_pkg::LVL_W-1:0] best;
        best = '0;
        sel.win_valid = 1'b0;
        sel.win_idx = '0;
        for (int i = pivec_pkg::NUM_ENT - 1; i >= 0; i--) begin
            if (sel.elig[i] && (!sel.win_valid || sel.lvl[i] >= best)) begin
                sel.win_valid = 1'b1;
                sel.win_idx = 5'(i);
                best = sel.lvl[i];
            end
        end
    end

endmodule

`default_nettype wire

// file: bench/pivec_cpu_model.sv
// Processor model that acknowledges presented interrupt requests.
// Assumes the controller holds its request until the acknowledge is taken.
`timescale 1ns/1ps
`default_nettype none

module pivec_cpu_model (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    // Bench control: service on or off, cycles of delay before each acknowledge.
    input wire logic i_en,
    input wire logic [1:0] i_dly,
    // Controller side.
    input wire logic i_irq_req,
    output logic o_irq_ack
);
    logic [1:0] cnt_q;

    ////////////////////////////////////////////////////////////////////////////////
    // A delay of zero keeps the acknowledge high, which gives back-to-back acks.
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_irq_ack <= 1'b0;
            cnt_q <= 2'h0;
        end else if (i_en && i_irq_req && cnt_q >= i_dly) begin
            o_irq_ack <= 1'b1;
            cnt_q <= 2'h0;
        end else begin
            o_irq_ack <= 1'b0;
            cnt_q <= (i_en && i_irq_req) ? cnt_q + 2'h1 : 2'h0;
        end
    end
endmodule

`default_nettype wire

// file: bench/tb_prioritized_interrupt_vectoring.sv
// Self-checking bench for the interrupt vectoring top with a processor model.
// Assumes the design package is compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb_prioritized_interrupt_vectoring;
    logic i_sys_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic [7:0] i_periph_pulse = 8'h00;
    logic [2:0] i_trap_pulse = 3'h0;
    logic [7:0] i_pa_pin = 8'h00;
    logic [7:0] i_pa_edge_fall = 8'h00;
    logic [3:0] i_pc_pin = 4'h0;
    logic i_master_irq_enable = 1'b1;
    logic [19:0] i_src_enable = 20'hf_ffff;
    logic [39:0] i_src_level = 40'h55_5555_5555;
    logic [19:0] i_sw_set = 20'h0_0000;
    logic [19:0] i_sw_clear = 20'h0_0000;
    logic cpu_en = 1'b0;
    logic [1:0] cpu_dly = 2'h0;
    logic o_irq_req, o_irq_is_trap, i_irq_ack;
    logic [15:0] o_vec_msb_addr, o_vec_lsb_addr;
    logic [19:0] o_pending, pend_e, mask;
    logic [16:0] expq[$];
    logic [16:0] e;
    logic [7:0] pa_old, pa_n;
    logic [3:0] pc_old, pc_n;
    int num_errors = 0;
    int n_compared = 0;
    int seed = 32'h7bc3a4c1;

    always #2 i_sys_clk = ~i_sys_clk;

    pivec_top i_dut (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_periph_pulse(i_periph_pulse),
        .i_trap_pulse(i_trap_pulse), .i_pa_pin(i_pa_pin), .i_pa_edge_fall(i_pa_edge_fall),
        .i_pc_pin(i_pc_pin), .i_master_irq_enable(i_master_irq_enable),
        .i_src_enable(i_src_enable), .i_src_level(i_src_level), .i_sw_set(i_sw_set),
        .i_sw_clear(i_sw_clear), .o_irq_req(o_irq_req), .o_vec_msb_addr(o_vec_msb_addr),
        .o_vec_lsb_addr(o_vec_lsb_addr), .o_irq_is_trap(o_irq_is_trap), .i_irq_ack(i_irq_ack),
        .o_pending(o_pending));

    pivec_cpu_model i_cpu (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_en(cpu_en),
        .i_dly(cpu_dly), .i_irq_req(o_irq_req), .o_irq_ack(i_irq_ack));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (num_errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic cmp_w(input logic [19:0] got, input logic [19:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: word %h, want %h", $time, got, exp);
        end
    endtask

    task automatic cmp_b(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: flag %b, want %b", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge i_sys_clk);
    endtask

    // Waits until every expected service is taken and the request has dropped.
    task automatic drain();
        int i;
        for (i = 0; i < 300 && (expq.size() > 0 || o_irq_req !== 1'b0); i++) tick(1);
        if (i == 300) begin
            num_errors++;
            $display("unexpected at %0t: service timeout", $time);
            end_of_test();
        end
    endtask

    function automatic logic [15:0] src_vec(input int k);
        case (k)
            0: return 16'h0004;
            1: return 16'h000a;
            2: return 16'h000c;
            3: return 16'h000e;
            4: return 16'h0010;
            5: return 16'h0016;
            6, 7: return 16'h0018;
            8, 9: return 16'h001a;
            default: return (k < 16) ? 16'h001c + 16'(2 * (k - 10)) : 16'h0030 + 16'(2 * (k - 16));
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // The acknowledge seen here is taken at the next rising edge.
    always @(negedge i_sys_clk) begin
        if (i_arst_n && i_irq_ack === 1'b1 && o_irq_req === 1'b1) begin
            if (expq.size() == 0) begin
                num_errors++;
                $display("unexpected at %0t: extra service", $time);
            end else begin
                e = expq.pop_front();
                cmp_w({3'h0, o_irq_is_trap, o_vec_msb_addr}, {3'h0, e});
                cmp_w({4'h0, o_vec_lsb_addr}, {4'h0, e[15:0] | 16'h0001});
            end
        end
    end

    initial begin
        int k;
        int lv;
        tick(12);
        cmp_b(o_irq_req, 1'b0);
        cmp_w(o_pending, 20'h0_0000);
        i_arst_n = 1'b1;
        tick(1);
        cmp_w({3'h0, o_irq_req, o_vec_msb_addr}, {4'h1, 16'h0002});
        cmp_w({3'h0, o_irq_is_trap, o_vec_lsb_addr}, {4'h1, 16'h0003});
        expq.push_back({1'b1, 16'h0002});
        cpu_en = 1'b1;
        drain();
        // Everything at once, level 1 except the top-level watchdog and traps: the fixed ranking alone decides the order.
        cpu_dly = 2'($random(seed));
        expq.push_back({1'b0, 16'h0004});
        expq.push_back({1'b1, 16'h003a});
        expq.push_back({1'b1, 16'h003c});
        expq.push_back({1'b1, 16'h0006});
        for (k = 1; k < 20; k++) expq.push_back({1'b0, src_vec(k)});
        i_periph_pulse = 8'hff;
        i_trap_pulse = 3'h7;
        i_pa_pin = 8'hff;
        i_pc_pin = 4'hf;
        tick(1);
        i_periph_pulse = 8'h00;
        i_trap_pulse = 3'h0;
        drain();
        pa_old = 8'hff;
        pc_old = 4'hf;
        // Random levels and software requests.
        repeat (6) begin
            i_src_level = 40'({$random(seed), $random(seed)});
            mask = 20'($random(seed));
            cpu_dly = 2'($random(seed));
            for (lv = 3; lv >= 0; lv--) begin
                for (k = 0; k < 20; k++) begin
                    if (mask[k] && ((k == 0) ? 2'h3 : i_src_level[2*k+:2]) == 2'(lv)) begin
                        expq.push_back({1'b0, src_vec(k)});
                    end
                end
            end
            i_sw_set = mask;
            tick(1);
            i_sw_set = 20'h0_0000;
            drain();
        end
        // Master enable off: interrupts wait, traps still go through.
        i_master_irq_enable = 1'b0;
        i_periph_pulse = 8'h04;
        tick(1);
        i_periph_pulse = 8'h00;
        tick(2);
        cmp_b(o_irq_req, 1'b0);
        cmp_w(o_pending, 20'h0_0004);
        expq.push_back({1'b1, 16'h0006});
        i_trap_pulse = 3'h4;
        tick(1);
        i_trap_pulse = 3'h0;
        drain();
        cmp_w(o_pending, 20'h0_0004);
        i_sw_clear = 20'h0_0004;
        tick(1);
        i_sw_clear = 20'h0_0000;
        tick(1);
        cmp_w(o_pending, 20'h0_0000);
        i_master_irq_enable = 1'b1;
        i_src_enable = 20'h0_0000;
        i_periph_pulse = 8'h01;
        tick(1);
        i_periph_pulse = 8'h00;
        tick(2);
        cmp_b(o_irq_req, 1'b0);
        cmp_w(o_pending, 20'h0_0001);
        expq.push_back({1'b0, 16'h0004});
        i_src_enable = 20'hf_ffff;
        drain();
        // Pin edges with random edge selection, seen through the pending bits.
        i_master_irq_enable = 1'b0;
        cpu_en = 1'b0;
        repeat (10) begin
            pa_n = 8'($random(seed));
            pc_n = 4'($random(seed));
            i_pa_edge_fall = 8'($random(seed));
            tick(1);
            pend_e = 20'h0_0000;
            for (k = 0; k < 8; k++) begin
                if (pa_n[k] != pa_old[k] && pa_n[k] != i_pa_edge_fall[k]) begin
                    pend_e[(k == 7) ? 6 : (k == 6) ? 8 : 15 - k] = 1'b1;
                end
            end
            for (k = 0; k < 4; k++) if (pc_n[k] != pc_old[k]) pend_e[19-k] = 1'b1;
            i_pa_pin = pa_n;
            i_pc_pin = pc_n;
            tick(2);
            cmp_w(o_pending, pend_e);
            pa_old = pa_n;
            pc_old = pc_n;
            i_sw_clear = 20'hf_ffff;
            tick(1);
            i_sw_clear = 20'h0_0000;
            tick(1);
        end
        end_of_test();
    end
endmodule

`default_nettype wire
